// *** logic/fdl_pkg.sv ***
package fdl_pkg;
    // Clocking
    localparam int CLK_HZ = 250_000_000;
    localparam int OSC_HZ = 10_000_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // Table word rate in centihertz (156.25 kHz)
    localparam int WORD_HZ_X100 = 15_625_000;
    localparam int WORD_DIV = int'((64'(CLK_HZ) * 100) / WORD_HZ_X100);
    localparam int WINDOW_WORDS = 375;
    // Debounce delay, least time, rounded up
    localparam int DEBOUNCE_US = 10_000;
    localparam int DEBOUNCE_CYC =
        int'((64'(CLK_HZ) * DEBOUNCE_US + 999_999) / 1_000_000);
    // Serial clock half period, least time, rounded up
    localparam int SCK_HALF_NS = 64;
    localparam int SCK_HALF_CALC =
        int'((64'(SCK_HALF_NS) * CLK_HZ + 999_999_999) / 1_000_000_000);
    localparam int SCK_HALF = (SCK_HALF_CALC < 1) ? 1 : SCK_HALF_CALC;
    localparam logic SPI_CPOL = 1'b0;
    // Page read frame
    localparam logic [7:0] READ_OPCODE = 8'hd2;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic [7:0] PAGE_OFFSET = 8'h00;
    localparam logic [7:0] MOSI_IDLE_BYTE = 8'hff;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 4;
    localparam int TX_BYTES = 1 + ADDR_BYTES + DUMMY_BYTES;
    localparam int RX_BYTES = 3;
    localparam int FRAME_BYTES = TX_BYTES + RX_BYTES;
    localparam int FRAMES = 2;
    // Target register layout
    localparam logic [15:0] REG_MSB_ADDR = 16'h012f;
    localparam logic [15:0] REG_LSB_ADDR = 16'h0130;
    localparam logic [15:0] RESET_RELOAD = 16'h2710;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_BIT   = 2'h1,
        ST_PAUSE = 2'h2,
        ST_GAP   = 2'h3
    } fdl_spi_state_t;
endpackage

// *** logic/fdl_fifo.sv ***
`timescale 1ns/1ns
module fdl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  logic             clk_i,
    input  logic             nrst_i,
    input  logic             in_valid_i,
    output logic             in_ready_o,
    input  logic [WIDTH-1:0] in_data_i,
    output logic             out_valid_o,
    input  logic             out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Wrap by compare so a non power of two depth works
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    property p_no_overflow;
        @(posedge clk_i) disable iff (!nrst_i) cnt_q <= CW'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo count above depth");
endmodule

// *** logic/fdl_loader.sv ***
// Overview of operation
// - Mode 0: clock idles low, sample on rise, shift on fall.
// - Mode 3: clock idles high, sample on rise, shift on fall.
// - After reset the divider reload is 10000, giving 1 kHz.
// - First press loads 5000 from flash, output becomes 2 kHz.
// - Second press loads 2500 from the next pages, output 4 kHz.
// - Loader is SPI master driving select, clock and data out.
// - Word counter only times the window; serializer shifts out the page read frames.
// - Rising start fires a one-shot lasting exactly 375 table words.
// - Word counter advances at 156.25 kHz; window is period times count.
// - Serializer clock runs only while the one-shot is high.
// - Button passes a delay debounce before starting a reload.
// - Toggle flop flips per press and picks one of two page ranges.
// - Reads use mode 0, select and data idle high, one-clock byte pause.
// - Page read: opcode d2, three address bytes, four dummy bytes.
// - Select stays low through the whole read; raising it ends it.
// - High byte at 12f and low byte at 130 come in separate frames.
`timescale 1ns/1ns
module fdl_loader #(
    parameter int   DEBOUNCE_CYCLES = fdl_pkg::DEBOUNCE_CYC,
    parameter logic CPOL            = fdl_pkg::SPI_CPOL,
    parameter int   WINDOW_WORDS    = fdl_pkg::WINDOW_WORDS
) (
    input  logic clk_i,
    input  logic nrst_i,
    input  logic button_i,
    input  logic spi_miso_i,
    output logic spi_cs_n_o,
    output logic spi_sck_o,
    output logic spi_mosi_o,
    output logic div_out_o,
    output logic busy_o,
    output logic range_o
);
    localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int WW  = $clog2(WINDOW_WORDS + 1);
    localparam int HALF = fdl_pkg::SCK_HALF;
    localparam int WIN_CYCLES = fdl_pkg::WORD_DIV * WINDOW_WORDS;
    localparam int FB_BITS = fdl_pkg::FRAME_BYTES * 8;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Pin synchronisers
    logic [1:0] btn_sync_q;
    logic [1:0] miso_sync_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            btn_sync_q  <= 2'h0;
            miso_sync_q <= 2'h3;
        end else begin
            btn_sync_q  <= {btn_sync_q[0], button_i};
            miso_sync_q <= {miso_sync_q[0], spi_miso_i};
        end
    end

    // Debounce: level must hold for the full delay
    logic           btn_stable_q;
    logic           btn_prev_q;
    logic [DBW-1:0] deb_cnt_q;
    logic           window_q;
    logic           press_ok;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            btn_stable_q <= 1'b0;
            btn_prev_q   <= 1'b0;
            deb_cnt_q    <= '0;
        end else begin
            btn_prev_q <= btn_stable_q;
            if (btn_sync_q[1] == btn_stable_q) begin
                deb_cnt_q <= '0;
            end else if (deb_cnt_q == DBW'(DEBOUNCE_CYCLES - 1)) begin
                btn_stable_q <= btn_sync_q[1];
                deb_cnt_q    <= '0;
            end else begin
                deb_cnt_q <= deb_cnt_q + 1'b1;
            end
        end
    end
    // Presses during a running window are dropped to keep pages paired
    assign press_ok = btn_stable_q & ~btn_prev_q & ~window_q;

    // Range toggle and page pair for this sequence
    logic range_q;
    logic page_sel_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            range_q    <= 1'b0;
            page_sel_q <= 1'b0;
        end else if (press_ok) begin
            page_sel_q <= range_q;
            range_q    <= ~range_q;
        end
    end

    // One-shot window timed by the table word counter
    logic [$clog2(fdl_pkg::WORD_DIV)-1:0] wdiv_q;
    logic [WW-1:0]                        word_cnt_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            window_q   <= 1'b0;
            wdiv_q     <= '0;
            word_cnt_q <= '0;
        end else if (press_ok) begin
            window_q   <= 1'b1;
            wdiv_q     <= '0;
            word_cnt_q <= '0;
        end else if (window_q) begin
            if (wdiv_q == ($bits(wdiv_q))'(fdl_pkg::WORD_DIV - 1)) begin
                wdiv_q     <= '0;
                word_cnt_q <= word_cnt_q + 1'b1;
                if (word_cnt_q == WW'(WINDOW_WORDS - 1)) begin
                    window_q <= 1'b0;
                end
            end else begin
                wdiv_q <= wdiv_q + 1'b1;
            end
        end
    end

    // Serializer state machine
    fdl_pkg::fdl_spi_state_t state_q;
    logic [7:0]  cnt_q;
    logic        phase_q;
    logic [2:0]  bit_q;
    logic [3:0]  byte_q;
    logic [1:0]  frame_q;
    logic [7:0]  rx_q;
    logic [7:0]  tx_cur;
    logic [11:0] page;
    logic        is_rx;
    logic        per_end;
    logic        push_valid;
    logic        fifo_in_ready;

    assign page    = {10'h000, page_sel_q, frame_q[0]};
    assign is_rx   = (byte_q >= 4'(fdl_pkg::TX_BYTES));
    assign per_end = (cnt_q == 8'(2 * HALF - 1));
    assign push_valid = window_q && (state_q == fdl_pkg::ST_PAUSE)
                        && per_end && is_rx;

    // Outgoing byte for the current position of the frame
    always_comb begin
        tx_cur = fdl_pkg::DUMMY_BYTE;
        if (byte_q == 4'h0) begin
            tx_cur = fdl_pkg::READ_OPCODE;
        end else if (byte_q == 4'h1) begin
            tx_cur = {4'h0, page[11:8]};
        end else if (byte_q == 4'h2) begin
            tx_cur = page[7:0];
        end else if (byte_q == 4'h3) begin
            tx_cur = fdl_pkg::PAGE_OFFSET;
        end else if (is_rx) begin
            tx_cur = fdl_pkg::MOSI_IDLE_BYTE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= fdl_pkg::ST_IDLE;
            cnt_q   <= '0;
            phase_q <= 1'b0;
            bit_q   <= 3'h7;
            byte_q  <= '0;
            frame_q <= '0;
            rx_q    <= '0;
        end else if (!window_q) begin
            state_q <= fdl_pkg::ST_IDLE;
            cnt_q   <= '0;
            if (press_ok) begin
                frame_q <= '0;
            end
        end else begin
            unique case (state_q)
                fdl_pkg::ST_IDLE: begin
                    if (frame_q < 2'(fdl_pkg::FRAMES)) begin
                        state_q <= fdl_pkg::ST_BIT;
                        cnt_q   <= '0;
                        phase_q <= 1'b0;
                        bit_q   <= 3'h7;
                        byte_q  <= '0;
                    end
                end
                fdl_pkg::ST_BIT: begin
                    if (cnt_q == 8'(HALF - 1)) begin
                        cnt_q   <= '0;
                        phase_q <= ~phase_q;
                        if (phase_q) begin
                            rx_q <= {rx_q[6:0], miso_sync_q[1]};
                            if (bit_q == 3'h0) begin
                                state_q <= fdl_pkg::ST_PAUSE;
                            end else begin
                                bit_q <= bit_q - 1'b1;
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                fdl_pkg::ST_PAUSE: begin
                    // A full fifo stretches the pause
                    if (per_end && !(is_rx && !fifo_in_ready)) begin
                        cnt_q <= '0;
                        bit_q <= 3'h7;
                        if (byte_q == 4'(fdl_pkg::FRAME_BYTES - 1)) begin
                            state_q <= fdl_pkg::ST_GAP;
                        end else begin
                            state_q <= fdl_pkg::ST_BIT;
                            byte_q  <= byte_q + 1'b1;
                        end
                    end else if (!per_end) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                fdl_pkg::ST_GAP: begin
                    if (per_end) begin
                        cnt_q   <= '0;
                        frame_q <= frame_q + 1'b1;
                        state_q <= fdl_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // Link pins, one cycle behind the state they reflect
    logic cs_n_q;
    logic sck_q;
    logic mosi_q;
    logic in_frame;
    assign in_frame = window_q && (state_q == fdl_pkg::ST_BIT
                                   || state_q == fdl_pkg::ST_PAUSE);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_n_q <= 1'b1;
            sck_q  <= CPOL;
            mosi_q <= 1'b1;
        end else begin
            cs_n_q <= ~in_frame;
            // Low half first in both modes; only the idle level differs
            sck_q  <= (in_frame && state_q == fdl_pkg::ST_BIT)
                      ? phase_q : CPOL;
            mosi_q <= (in_frame && state_q == fdl_pkg::ST_BIT)
                      ? tx_cur[bit_q] : 1'b1;
        end
    end
    assign spi_cs_n_o = cs_n_q;
    assign spi_sck_o  = sck_q;
    assign spi_mosi_o = mosi_q;

    // Oscillator tick paces the register side and drains the fifo
    logic [$clog2(fdl_pkg::OSC_DIV)-1:0] osc_q;
    logic                                osc_tick;
    assign osc_tick = (osc_q == ($bits(osc_q))'(fdl_pkg::OSC_DIV - 1));
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_q <= '0;
        end else begin
            osc_q <= osc_tick ? '0 : osc_q + 1'b1;
        end
    end

    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       pop;
    assign pop = fifo_out_valid & osc_tick;

    fdl_fifo #(
        .WIDTH (fdl_pkg::FIFO_WIDTH),
        .DEPTH (fdl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rx_q),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (osc_tick),
        .out_data_o  (fifo_out_data)
    );

    // Byte stream: address high, address low, data
    logic [1:0]  pos_q;
    logic [15:0] addr_q;
    logic [7:0]  msb_q;
    logic [15:0] pend_q;
    logic        pend_set;
    assign pend_set = pop && (pos_q == 2'h2)
                      && (addr_q == fdl_pkg::REG_LSB_ADDR);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_q  <= '0;
            addr_q <= '0;
            msb_q  <= fdl_pkg::RESET_RELOAD[15:8];
            pend_q <= fdl_pkg::RESET_RELOAD;
        end else if (press_ok) begin
            pos_q <= '0;
        end else if (pop) begin
            unique case (pos_q)
                2'h0: addr_q[15:8] <= fifo_out_data;
                2'h1: addr_q[7:0]  <= fifo_out_data;
                default: begin
                    if (addr_q == fdl_pkg::REG_MSB_ADDR) begin
                        msb_q <= fifo_out_data;
                    end
                    if (pend_set) begin
                        pend_q <= {msb_q, fifo_out_data};
                    end
                end
            endcase
            pos_q <= (pos_q == 2'h2) ? 2'h0 : pos_q + 1'b1;
        end
    end

    // Output divider; a new value takes effect at the next period
    logic [15:0] reload_q;
    logic [15:0] div_cnt_q;
    logic        pend_v_q;
    logic        div_q;
    logic        loaded_q;
    logic        wrap;
    assign wrap = osc_tick && (div_cnt_q >= reload_q - 16'h0001);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_v_q <= 1'b0;
        end else if (pend_set) begin
            pend_v_q <= 1'b1;
        end else if (wrap) begin
            pend_v_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reload_q  <= fdl_pkg::RESET_RELOAD;
            div_cnt_q <= '0;
            div_q     <= 1'b1;
            loaded_q  <= 1'b0;
        end else if (osc_tick) begin
            if (wrap) begin
                div_cnt_q <= '0;
                div_q     <= 1'b1;
                if (pend_v_q) begin
                    reload_q <= pend_q;
                    loaded_q <= 1'b1;
                end
            end else begin
                div_cnt_q <= div_cnt_q + 1'b1;
                div_q <= (div_cnt_q + 16'h0001) < {1'b0, reload_q[15:1]};
            end
        end
    end
    assign div_out_o = div_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o  <= 1'b0;
            range_o <= 1'b0;
        end else begin
            busy_o  <= window_q;
            range_o <= range_q;
        end
    end

    // Checks
    logic [$clog2(WIN_CYCLES + 1)-1:0] win_len_q;
    logic [7:0]                        rises_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            win_len_q <= '0;
            rises_q   <= '0;
        end else begin
            win_len_q <= press_ok ? '0 : win_len_q + (window_q ? 1'b1 : 1'b0);
            if (cs_n_q) begin
                rises_q <= '0;
            end else if (!sck_q && (in_frame && state_q == fdl_pkg::ST_BIT
                                    && phase_q)) begin
                rises_q <= rises_q + 1'b1;
            end
        end
    end

    property p_gate_stop;
        !window_q |=> spi_cs_n_o && state_q == fdl_pkg::ST_IDLE;
    endproperty
    a_gate_stop: assert property (p_gate_stop)
        else $error("link active outside window");
    property p_sck_idle;
        spi_cs_n_o |-> spi_sck_o == CPOL;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock not idle");
    property p_mosi_idle;
        spi_cs_n_o |-> spi_mosi_o;
    endproperty
    a_mosi_idle: assert property (p_mosi_idle)
        else $error("data out not idle high");
    property p_window_len;
        $fell(window_q) |-> win_len_q == ($bits(win_len_q))'(WIN_CYCLES);
    endproperty
    a_window_len: assert property (p_window_len)
        else $error("window length wrong");
    property p_range;
        press_ok |=> range_q != $past(range_q) && page_sel_q == $past(range_q);
    endproperty
    a_range: assert property (p_range)
        else $error("range did not toggle");
    property p_reset_reload;
        !loaded_q |-> reload_q == fdl_pkg::RESET_RELOAD;
    endproperty
    a_reset_reload: assert property (p_reset_reload)
        else $error("reset reload changed");
    property p_frame_bits;
        $rose(spi_cs_n_o) && $past(window_q, 2) |-> rises_q == 8'(FB_BITS);
    endproperty
    a_frame_bits: assert property (p_frame_bits)
        else $error("frame bit count wrong");
    property p_pause_low;
        window_q && state_q == fdl_pkg::ST_PAUSE ##1 window_q
            |-> !spi_cs_n_o && spi_sck_o == CPOL;
    endproperty
    a_pause_low: assert property (p_pause_low)
        else $error("byte pause broken");
    property p_debounce;
        $changed(btn_stable_q)
            |-> $past(deb_cnt_q) == DBW'(DEBOUNCE_CYCLES - 1);
    endproperty
    a_debounce: assert property (p_debounce)
        else $error("button accepted early");
    property p_load;
        pend_set |=> pend_v_q && pend_q == {$past(msb_q), $past(fifo_out_data)};
    endproperty
    a_load: assert property (p_load)
        else $error("reload value not captured");

    c_press: cover property (press_ok);
    c_load: cover property (wrap && pend_v_q);
    c_second: cover property (frame_q == 2'h2 && window_q);
endmodule

// *** test/fdl_flash_model.sv ***
`timescale 1ns/1ns
module fdl_flash_model (
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic mosi_i,
    output logic      miso_o
);
    // Pages 0..3, three bytes each: address hi, address lo, data
    // Main array only; write buffers sit outside this read path
    logic [7:0]  mem [0:11];
    logic [31:0] sh;
    logic [11:0] page;
    int          nbit;
    initial begin
        mem = '{8'h01, 8'h2f, 8'h13, 8'h01, 8'h30, 8'h88,
                8'h01, 8'h2f, 8'h09, 8'h01, 8'h30, 8'hc4};
        miso_o = 1'b0;
        nbit = 0;
        page = 12'h000;
    end
    always @(negedge cs_n_i) nbit = 0;
    // Released line floats: flip it so stale data never matches
    always @(posedge cs_n_i) miso_o = ~miso_o;
    always @(posedge sck_i) begin
        if (cs_n_i === 1'b0) begin
            sh = {sh[30:0], mosi_i};
            nbit++;
            if (nbit == 32) page = sh[19:8];
        end
    end
    always @(negedge sck_i) begin
        if (cs_n_i === 1'b0 && nbit >= 64 && nbit < 88 && page < 4) begin
            miso_o = mem[page * 3 + (nbit - 64) / 8][7 - (nbit - 64) % 8];
        end
    end
endmodule

// *** test/fdl_loader_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch t=%0t %s", $time, m); end end
module fdl_loader_bench;
    localparam int DEB = 50;
    localparam int WW  = 6;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       button_i = 1'b0;
    logic       miso, cs_n, sck, mosi, div_out, busy, rng;
    logic       miso3, cs3, sck3, mosi3;
    logic       mosi_prev = 1'b1;
    logic       div_low = 1'b0;
    logic [7:0] sh;
    logic [7:0] exp_byte [$];
    logic       exp_rng [$];
    int         error_cnt = 0;
    int         checked = 0;
    int         seed = 32'h316c;
    int         nb = 0;
    int         hi = 0;

    fdl_loader #(.DEBOUNCE_CYCLES(DEB), .CPOL(1'b0), .WINDOW_WORDS(WW))
    fdl_loader_i (.clk_i(clk_i), .nrst_i(nrst_i), .button_i(button_i),
        .spi_miso_i(miso), .spi_cs_n_o(cs_n), .spi_sck_o(sck),
        .spi_mosi_o(mosi), .div_out_o(div_out), .busy_o(busy),
        .range_o(rng));
    fdl_flash_model fdl_flash_model_i (.cs_n_i(cs_n), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso));
    // Mode 3 twin: idle clock level and fetched value are checked
    fdl_loader #(.DEBOUNCE_CYCLES(DEB), .CPOL(1'b1), .WINDOW_WORDS(WW))
    fdl_loader_m3_i (.clk_i(clk_i), .nrst_i(nrst_i), .button_i(button_i),
        .spi_miso_i(miso3), .spi_cs_n_o(cs3), .spi_sck_o(sck3),
        .spi_mosi_o(mosi3), .div_out_o(), .busy_o(), .range_o());
    fdl_flash_model fdl_flash_model_m3_i (.cs_n_i(cs3), .sck_i(sck3),
        .mosi_i(mosi3), .miso_o(miso3));

    initial forever #2 clk_i = ~clk_i;

    always @(posedge sck) begin
        if (cs_n === 1'b0) begin
            sh = {sh[6:0], mosi};
            nb++;
            if (nb % 8 == 0) begin
                if (exp_byte.size() == 0) `CHK(1'b1, 1'b0, "extra byte")
                else `CHK(sh, exp_byte.pop_front(), "frame byte")
            end
        end
    end
    always @(negedge cs_n) begin
        nb = 0;
        `CHK(sck, 1'b0, "clock idle at select")
    end
    always @(posedge cs_n) if (nb != 0) `CHK(nb, 88, "bits per frame")
    // Looked at on the settled half, so a same-edge clock fall is no race
    always @(negedge clk_i) begin
        if (cs_n === 1'b0 && sck === 1'b1 && mosi !== mosi_prev)
            `CHK(1'b0, 1'b1, "data moved while clock high")
        mosi_prev = mosi;
    end
    always @(posedge cs3) if (nrst_i) `CHK(sck3, 1'b1, "mode 3 idle")
    always @(posedge clk_i) begin
        if (busy === 1'b1) hi++;
        if (nrst_i && div_out !== 1'b1) div_low = 1'b1;
    end
    always @(posedge busy) begin
        #1;
        if (exp_rng.size() == 0) `CHK(1'b1, 1'b0, "extra window")
        else `CHK(rng, exp_rng.pop_front(), "range flip")
    end
    always @(negedge busy) begin
        if (hi != 0) `CHK(hi, WW * fdl_pkg::WORD_DIV, "window len")
        hi = 0;
    end

    task automatic bounce(input logic lvl, input int n);
        repeat (6) begin
            @(posedge clk_i);
            button_i <= 1'($random(seed));
        end
        @(posedge clk_i);
        button_i <= lvl;
        repeat (n) @(posedge clk_i);
    endtask

    // Full press with a refused re-press inside the window
    task automatic press(input logic [11:0] pg, input logic r,
                         input logic [15:0] val);
        logic [11:0] p;
        for (int f = 0; f < 2; f++) begin
            p = pg + 12'(f);
            exp_byte.push_back(8'hd2);
            exp_byte.push_back({4'h0, p[11:8]});
            exp_byte.push_back(p[7:0]);
            for (int i = 0; i < 5; i++) exp_byte.push_back(8'h00);
            for (int i = 0; i < 3; i++) exp_byte.push_back(8'hff);
        end
        exp_rng.push_back(r);
        bounce(1'b1, DEB + 20);
        `CHK(busy, 1'b1, "window start")
        bounce(1'b0, DEB + 20);
        bounce(1'b1, DEB + 20);
        bounce(1'b0, DEB + 20);
        for (int i = 0; i < WW * 1700 && busy !== 1'b0; i++) @(posedge clk_i);
        repeat (100) @(posedge clk_i);
        `CHK(exp_byte.size(), 0, "frames done")
        `CHK(rng, r, "range after window")
        `CHK(fdl_loader_i.pend_q, val, "fetched reload")
        `CHK(fdl_loader_m3_i.pend_q, val, "mode 3 fetched reload")
        $display("test press page %0d done", pg);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(4 * 60000);
        error_cnt++;
        $display("mismatch t=%0t %s", $time, "timeout");
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        `CHK({cs_n, sck, mosi, div_out, busy, rng}, 6'b101100, "reset")
        `CHK(sck3, 1'b1, "mode 3 reset idle")
        $display("test reset done");
        @(posedge clk_i);
        button_i <= 1'b1;
        repeat (DEB - 10) @(posedge clk_i);
        button_i <= 1'b0;
        repeat (DEB + 20) @(posedge clk_i);
        `CHK(busy, 1'b0, "short pulse ignored")
        $display("test glitch done");
        // Reload 5000 after the first press, 2500 after the second
        press(12'h000, 1'b1, 16'h1388);
        press(12'h002, 1'b0, 16'h09c4);
        // Reload 10000 keeps the output high far beyond this run
        `CHK(div_low, 1'b0, "divider first half")
        $display("test divider done");
        report_and_stop();
    end
endmodule
